// >>> hdl/cpm_cfg.svh
// constants for the cpu clock and power monitor block
// Behaviour
// - clock output runs at cpu clock over six
// - clock output keeps toggling in idle mode
// - clock output only with rc or external clock
// - second oscillator pin is port pin otherwise
// - machine cycle six clocks, compat bit halves
// - halving also slows peripheral timing
// - divider zero gives oscillator or its half
// - divider n divides by two times n plus two
// - divider rewritable anytime without disturbing execution
// - brownout resets by default, interrupt if selected
// - level select one is 2.5 V, zero 3.8 V
// - brownout reset held while supply stays low
// - brownout interrupt once per falling crossing
// - brownout irq needs global and own enable
// - brownout flag sticky until software clears
// - brownout disable suppresses reset and interrupt
// - power on flag sticky until software clears
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH
`define CPM_ADDR_CTRL      12'h000
`define CPM_ADDR_DIV       12'h004
`define CPM_ADDR_STATUS    12'h008
`define CPM_ADDR_IRQ_EN    12'h00C
`define CPM_ADDR_IRQ_CLR   12'h010
`define CPM_ADDR_POWER     12'h014
`define CPM_CTRL_CLKOUT    0
`define CPM_CTRL_BOI       1
`define CPM_CTRL_BOD       2
`define CPM_CTRL_GIE       3
`define CPM_CTRL_EBO       4
`define CPM_CTRL_RESET     8'h00
`define CPM_DIV_RESET      8'h00
`define CPM_CLKOUT_HALF    3'h3
`define CPM_OSC_RC         2'h2
`define CPM_OSC_EXT        2'h3
`define CPM_RESP_OKAY      2'h0
`define CPM_RESP_SLVERR    2'h2
`endif

// >>> hdl/cpm_pkg.sv
// types for the cpu clock and power monitor block
package cpm_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } cpm_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cpm_axi_rsp_t;
  typedef struct packed {
    logic        aw_got;
    logic [11:0] aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctrl;
    logic [7:0]  div_req;
    logic [7:0]  div_cur;
    logic [8:0]  div_cnt;
    logic        half_ph;
    logic        cpu_tick;
    logic [2:0]  co_cnt;
    logic [1:0]  co_sub;
    logic        clkout;
    logic        bo_s1;
    logic        bo_s2;
    logic        bo_s3;
    logic        bo_flag;
    logic        po_flag;
    logic        bo_irq;
    logic        por_seen;
  } cpm_state_t;
endpackage : cpm_pkg

// >>> hdl/cpm_top.sv
// clock division, clock output and brownout / power on monitor
`timescale 1ns/1ps
`default_nettype none
`include "cpm_cfg.svh"
module cpm_top
  import cpm_pkg::*;
(
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // register bus
  input  wire cpm_axi_req_t axi_req,
  output var cpm_axi_rsp_t  axi_rsp,
  // configuration word
  input  wire logic         compat_halving_bit,
  input  wire logic         brownout_level_select,
  input  wire logic [1:0]   osc_select,
  // analog monitors
  input  wire logic         brownout_below_raw,
  input  wire logic         power_on_detect,
  // pins and clock tick
  input  wire logic         port_pin_out,
  input  wire logic         port_pin_oe,
  output logic              clock_out_pin_o,
  output logic              clock_out_pin_oe,
  output logic              cpu_clk_tick,
  output logic              brownout_level_high,
  output logic              brownout_reset_n,
  output logic              irq
);
  cpm_state_t s_q;
  cpm_state_t s_d;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       co_allow;
  logic       bo_fall;
  logic [8:0] div_end;

  assign co_allow = (osc_select == `CPM_OSC_RC) || (osc_select == `CPM_OSC_EXT);
  // period of one tick in oscillator cycles less one; zero divider keeps full rate
  assign div_end  = (s_q.div_cur == 8'h00) ? 9'h000 : {s_q.div_cur, 1'b1};
  assign aw_take  = axi_req.awvalid && !s_q.aw_got && !s_q.bvalid;
  assign w_take   = axi_req.wvalid && !s_q.w_got && !s_q.bvalid;
  assign ar_take  = axi_req.arvalid && !s_q.rvalid;
  assign bo_fall  = s_q.bo_s2 && !s_q.bo_s3;

  always_comb
  begin
    logic        wr_go;
    logic [11:0] wa;
    logic        bo_set;
    logic        bo_clr;
    logic        po_clr;
    logic        irq_clr;
    s_d     = s_q;
    wr_go   = 1'b0;
    wa      = 12'h000;
    bo_set  = 1'b0;
    bo_clr  = 1'b0;
    po_clr  = 1'b0;
    irq_clr = 1'b0;
    if (aw_take)
    begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (w_take)
    begin
      s_d.w_got   = 1'b1;
      s_d.w_data  = axi_req.wdata;
      s_d.w_lane0 = axi_req.wstrb[0];
    end
    if (s_q.aw_got && s_q.w_got)
    begin
      wr_go      = 1'b1;
      wa         = s_q.aw_addr;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `CPM_RESP_OKAY;
      case ({wa[11:2], 2'b00})
        `CPM_ADDR_CTRL:
        begin
          if (s_q.w_lane0)
            s_d.ctrl = s_q.w_data[7:0];
        end
        `CPM_ADDR_DIV:
        begin
          if (s_q.w_lane0)
            s_d.div_req = s_q.w_data[7:0];
        end
        `CPM_ADDR_IRQ_CLR:
        begin
          if (s_q.w_lane0 && s_q.w_data[0])
            irq_clr = 1'b1;
        end
        `CPM_ADDR_POWER:
        begin
          if (s_q.w_lane0)
          begin
            bo_clr = s_q.w_data[1];
            po_clr = s_q.w_data[0];
          end
        end
        `CPM_ADDR_STATUS, `CPM_ADDR_IRQ_EN: s_d.bresp = `CPM_RESP_OKAY;
        default: s_d.bresp = `CPM_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && axi_req.bready)
      s_d.bvalid = 1'b0;
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `CPM_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      case ({axi_req.araddr[11:2], 2'b00})
        `CPM_ADDR_CTRL:    s_d.rdata[7:0] = s_q.ctrl;
        `CPM_ADDR_DIV:     s_d.rdata[7:0] = s_q.div_req;
        `CPM_ADDR_STATUS:  s_d.rdata[0]   = s_q.bo_irq;
        `CPM_ADDR_IRQ_EN:  s_d.rdata[0]   = s_q.ctrl[`CPM_CTRL_EBO];
        `CPM_ADDR_IRQ_CLR: s_d.rdata      = 32'h0000_0000;
        `CPM_ADDR_POWER:   s_d.rdata[1:0] = {s_q.bo_flag, s_q.po_flag};
        default:           s_d.rresp      = `CPM_RESP_SLVERR;
      endcase
    end
    else if (s_q.rvalid && axi_req.rready)
      s_d.rvalid = 1'b0;
    // divider: new ratio loaded only when the running period ends, no runt tick
    s_d.cpu_tick = 1'b0;
    if (s_q.div_cnt >= div_end)
    begin
      s_d.div_cnt = 9'h000;
      s_d.div_cur = s_q.div_req;
      if (!compat_halving_bit || s_q.half_ph)
        s_d.cpu_tick = 1'b1;
      s_d.half_ph = compat_halving_bit ? !s_q.half_ph : 1'b0;
    end
    else
      s_d.div_cnt = s_q.div_cnt + 9'h001;
    // clock out: three cpu ticks high, three low; runs in idle as well
    if (s_q.cpu_tick)
    begin
      if (s_q.co_cnt == `CPM_CLKOUT_HALF - 3'h1)
      begin
        s_d.co_cnt = 3'h0;
        s_d.clkout = !s_q.clkout;
      end
      else
        s_d.co_cnt = s_q.co_cnt + 3'h1;
    end
    s_d.co_sub = 2'h0;
    // brownout detector chain
    s_d.bo_s1 = brownout_below_raw;
    s_d.bo_s2 = s_q.bo_s1;
    s_d.bo_s3 = s_q.bo_s2;
    if (!s_q.ctrl[`CPM_CTRL_BOD] && s_q.bo_s2)
      bo_set = 1'b1;
    s_d.bo_flag = bo_set || (s_q.bo_flag && !bo_clr);
    s_d.po_flag = (power_on_detect && !s_q.por_seen) || (s_q.po_flag && !po_clr);
    if (power_on_detect)
      s_d.por_seen = 1'b1;
    s_d.bo_irq = (bo_fall && !s_q.ctrl[`CPM_CTRL_BOD] && s_q.ctrl[`CPM_CTRL_BOI])
                 || (s_q.bo_irq && !irq_clr);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q          <= '0;
      s_q.ctrl     <= `CPM_CTRL_RESET;
      s_q.div_req  <= `CPM_DIV_RESET;
      s_q.div_cur  <= `CPM_DIV_RESET;
      s_q.po_flag  <= 1'b1;
      s_q.por_seen <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  always_comb
  begin
    axi_rsp         = '0;
    axi_rsp.awready = aw_take;
    axi_rsp.wready  = w_take;
    axi_rsp.bvalid  = s_q.bvalid;
    axi_rsp.bresp   = s_q.bresp;
    axi_rsp.arready = ar_take;
    axi_rsp.rvalid  = s_q.rvalid;
    axi_rsp.rdata   = s_q.rdata;
    axi_rsp.rresp   = s_q.rresp;
  end

  assign cpu_clk_tick        = s_q.cpu_tick;
  assign brownout_level_high = !brownout_level_select;
  // reset path bypasses the synchroniser so it acts without a clock
  assign brownout_reset_n    = !(brownout_below_raw && !s_q.ctrl[`CPM_CTRL_BOD]
                                 && !s_q.ctrl[`CPM_CTRL_BOI]);
  assign irq = s_q.bo_irq && s_q.ctrl[`CPM_CTRL_GIE] && s_q.ctrl[`CPM_CTRL_EBO];
  // pin belongs to the port unless clock output owns it
  assign clock_out_pin_o  = (s_q.ctrl[`CPM_CTRL_CLKOUT] && co_allow) ? s_q.clkout
                                                                     : port_pin_out;
  assign clock_out_pin_oe = (s_q.ctrl[`CPM_CTRL_CLKOUT] && co_allow) ? 1'b1
                                                                     : port_pin_oe;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // helpers for the checks: a write lands in the cycle both halves are held
  logic wr_now;
  logic wr_pow;
  logic wr_clr;
  assign wr_now = s_q.aw_got && s_q.w_got;
  assign wr_pow = wr_now && s_q.w_lane0 && s_q.aw_addr[11:2] == 10'h005;
  assign wr_clr = wr_now && s_q.w_lane0 && s_q.aw_addr[11:2] == 10'h004;

  clkout_period_a: assert property ((s_q.cpu_tick && s_q.co_cnt == 3'h2) |=>
    s_q.clkout != $past(s_q.clkout))
    else $error("clock out did not toggle after third tick");
  clkout_hold_a: assert property (!s_q.cpu_tick |=> $stable(s_q.clkout))
    else $error("clock out moved without a tick");
  clkout_gate_a: assert property (!co_allow && !port_pin_oe |-> !clock_out_pin_oe)
    else $error("clock out driven with crystal");
  port_pin_a: assert property (!s_q.ctrl[0] |-> clock_out_pin_o == port_pin_out)
    else $error("port pin not passed through");
  half_tick_a: assert property (compat_halving_bit && s_q.cpu_tick
    && s_q.div_cur == 8'h00 |=> !s_q.cpu_tick)
    else $error("halved clock ticked twice in a row");
  full_rate_a: assert property (!compat_halving_bit && s_q.div_cur == 8'h00
    && s_q.div_req == 8'h00 ##1 !compat_halving_bit |-> s_q.cpu_tick)
    else $error("undivided clock missed a tick");
  div_ratio_a: assert property (s_q.div_cnt == 9'h000 && s_q.div_cur == 8'h01
    |-> s_q.div_cnt == 9'h000 ##1 s_q.div_cnt == 9'h001 ##1 s_q.div_cnt == 9'h002)
    else $error("divider count sequence wrong");
  div_boundary_a: assert property (s_q.div_cur != $past(s_q.div_cur)
    |-> s_q.div_cnt == 9'h000)
    else $error("divider changed mid period");
  bo_reset_a: assert property (brownout_below_raw && !s_q.ctrl[1] && !s_q.ctrl[2]
    |-> !brownout_reset_n)
    else $error("brownout reset not held");
  bo_once_a: assert property (s_q.bo_irq && !$past(s_q.bo_irq) |-> $past(bo_fall))
    else $error("brownout irq without falling crossing");
  irq_gate_a: assert property (irq |-> s_q.ctrl[3] && s_q.ctrl[4])
    else $error("irq without both enables");
  bo_flag_a: assert property (s_q.bo_s2 && !s_q.ctrl[2] |=> s_q.bo_flag)
    else $error("brownout flag not set");
  bo_off_a: assert property (s_q.ctrl[2] |-> brownout_reset_n)
    else $error("disabled brownout still resets");
  po_sticky_a: assert property (s_q.po_flag && !wr_pow |=> s_q.po_flag)
    else $error("power on flag lost");

  // register bus handshake
  awready_gate_a: assert property (axi_rsp.awready |-> !s_q.bvalid && !s_q.aw_got)
    else $error("address accepted while busy");
  wready_gate_a: assert property (axi_rsp.wready |-> !s_q.bvalid && !s_q.w_got)
    else $error("data accepted while busy");
  arready_gate_a: assert property (axi_rsp.arready |-> !s_q.rvalid)
    else $error("read accepted while answer pending");
  bvalid_hold_a: assert property (s_q.bvalid && !axi_req.bready |=> s_q.bvalid)
    else $error("write answer dropped early");
  rvalid_hold_a: assert property (s_q.rvalid && !axi_req.rready |=> s_q.rvalid)
    else $error("read answer dropped early");
  rdata_hold_a: assert property (s_q.rvalid && !axi_req.rready |=> $stable(s_q.rdata))
    else $error("read data moved while pending");
  bresp_hold_a: assert property (s_q.bvalid && !axi_req.bready |=> $stable(s_q.bresp))
    else $error("write response moved while pending");
  write_resp_a: assert property (wr_now |=> s_q.bvalid)
    else $error("write not answered");
  read_resp_a: assert property (ar_take |=> s_q.rvalid)
    else $error("read not answered");
  pair_clear_a: assert property (wr_now |=> !s_q.aw_got && !s_q.w_got)
    else $error("write halves not released");
  bvalid_drop_a: assert property (s_q.bvalid && axi_req.bready |=> !s_q.bvalid)
    else $error("write answer not retired");
  rvalid_drop_a: assert property (s_q.rvalid && axi_req.rready |=> !s_q.rvalid)
    else $error("read answer not retired");
  rd_unmapped_a: assert property (ar_take && axi_req.araddr[11:2] > 10'h005
    |=> s_q.rresp == `CPM_RESP_SLVERR)
    else $error("unmapped read not refused");
  rd_mapped_a: assert property (ar_take && axi_req.araddr[11:2] <= 10'h005
    |=> s_q.rresp == `CPM_RESP_OKAY)
    else $error("mapped read refused");
  rd_upper_zero_a: assert property (s_q.rvalid |-> s_q.rdata[31:8] == 24'h000000)
    else $error("unused read bits set");
  ctrl_write_a: assert property (wr_now && s_q.w_lane0 && s_q.aw_addr[11:2] == 10'h000
    |=> s_q.ctrl == $past(s_q.w_data[7:0]))
    else $error("control write lost");
  div_write_a: assert property (wr_now && s_q.w_lane0 && s_q.aw_addr[11:2] == 10'h001
    |=> s_q.div_req == $past(s_q.w_data[7:0]))
    else $error("divider write lost");
  no_lane_a: assert property (wr_now && !s_q.w_lane0
    |=> $stable(s_q.ctrl) && $stable(s_q.div_req))
    else $error("write landed without its lane");
  ctrl_only_bus_a: assert property (!wr_now |=> $stable(s_q.ctrl))
    else $error("control changed without a write");
  divreq_only_bus_a: assert property (!wr_now |=> $stable(s_q.div_req))
    else $error("divider request changed without a write");

  // cpu clock divider
  div_cnt_range_a: assert property (s_q.div_cnt <= div_end)
    else $error("divider count past its end");
  tick_at_wrap_a: assert property (s_q.cpu_tick |-> $past(s_q.div_cnt >= div_end))
    else $error("tick without period end");
  cnt_wrap_a: assert property (s_q.div_cnt >= div_end |=> s_q.div_cnt == 9'h000)
    else $error("divider count did not wrap");
  cnt_step_a: assert property (s_q.div_cnt < div_end
    |=> s_q.div_cnt == $past(s_q.div_cnt) + 9'h001)
    else $error("divider count skipped");
  no_halving_tick_a: assert property (!compat_halving_bit && s_q.div_cnt >= div_end
    |=> s_q.cpu_tick)
    else $error("tick missed at period end");
  halving_phase_a: assert property (compat_halving_bit && s_q.div_cnt >= div_end
    |=> s_q.half_ph != $past(s_q.half_ph))
    else $error("halving phase stuck");
  halving_skip_a: assert property (compat_halving_bit && s_q.div_cnt >= div_end
    && !s_q.half_ph |=> !s_q.cpu_tick)
    else $error("halved clock ticked on skipped phase");
  cur_stable_a: assert property (s_q.div_cnt < div_end |=> $stable(s_q.div_cur))
    else $error("divider ratio changed inside a period");
  cur_load_a: assert property (s_q.div_cnt >= div_end
    |=> s_q.div_cur == $past(s_q.div_req))
    else $error("new divider ratio not loaded");
  tick_pulse_a: assert property (s_q.div_cur != 8'h00 && s_q.cpu_tick
    |=> !s_q.cpu_tick)
    else $error("divided tick longer than one cycle");

  // clock output
  co_cnt_range_a: assert property (s_q.co_cnt <= 3'h2)
    else $error("clock out count out of range");
  co_step_a: assert property (s_q.cpu_tick && s_q.co_cnt != 3'h2
    |=> s_q.co_cnt == $past(s_q.co_cnt) + 3'h1 && $stable(s_q.clkout))
    else $error("clock out count skipped");
  co_idle_a: assert property (!s_q.cpu_tick |=> $stable(s_q.co_cnt))
    else $error("clock out counted without a tick");
  co_drive_a: assert property (s_q.ctrl[`CPM_CTRL_CLKOUT] && co_allow
    |-> clock_out_pin_oe && clock_out_pin_o == s_q.clkout)
    else $error("enabled clock out not on the pin");

  // brownout and power on
  sync_chain_a: assert property (s_q.bo_s2 == $past(s_q.bo_s1))
    else $error("synchroniser stage skipped");
  bo_irq_bod_a: assert property (s_q.ctrl[`CPM_CTRL_BOD] && !s_q.bo_irq
    |=> !s_q.bo_irq)
    else $error("disabled brownout raised irq");
  bo_irq_mode_a: assert property (!s_q.ctrl[`CPM_CTRL_BOI] && !s_q.bo_irq
    |=> !s_q.bo_irq)
    else $error("reset mode raised irq");
  bo_irq_clear_a: assert property (wr_clr && s_q.w_data[0] && !bo_fall
    |=> !s_q.bo_irq)
    else $error("irq status not cleared");
  bo_flag_hold_a: assert property (s_q.bo_flag && !(wr_pow && s_q.w_data[1])
    |=> s_q.bo_flag)
    else $error("brownout flag lost");
  bo_flag_clear_a: assert property (wr_pow && s_q.w_data[1] && !s_q.bo_s2
    |=> !s_q.bo_flag)
    else $error("brownout flag not cleared");
  po_clear_a: assert property (wr_pow && s_q.w_data[0] && s_q.por_seen
    |=> !s_q.po_flag)
    else $error("power on flag not cleared");
  bo_flag_off_a: assert property (s_q.ctrl[`CPM_CTRL_BOD] && !s_q.bo_flag
    |=> !s_q.bo_flag)
    else $error("disabled brownout set its flag");
  bo_release_a: assert property (!brownout_below_raw |-> brownout_reset_n)
    else $error("brownout reset held with good supply");
  level_sel_a: assert property (brownout_level_high != brownout_level_select)
    else $error("brownout level select wrong");
  por_seen_keep_a: assert property (s_q.por_seen |=> s_q.por_seen)
    else $error("power up record lost");

  cov_irq_c: cover property (irq);
  cov_bo_reset_c: cover property (!brownout_reset_n);
  cov_div_change_c: cover property (s_q.div_cur != $past(s_q.div_cur));
  cov_clkout_c: cover property (clock_out_pin_oe && $rose(s_q.clkout));
endmodule : cpm_top
`default_nettype wire

// >>> tb/cpm_clk_follower.sv
// follower device that times the clock output pad in aclk cycles
`timescale 1ns/1ps
`default_nettype none
module cpm_clk_follower
(
  // clock and pad
  input  wire logic aclk,
  input  wire logic pin,
  // last measured period
  output int        period
);
  int   cnt = 0;
  logic pin_q = 1'b0;
  initial period = 0;
  // times rising edge to rising edge, as an external device locking to the pad would
  always @(posedge aclk)
  begin
    pin_q <= pin;
    cnt   <= (pin && !pin_q) ? 1 : cnt + 1;
    if (pin && !pin_q)
      period <= cnt;
  end
endmodule : cpm_clk_follower
`default_nettype wire

// >>> tb/cpu_clock_and_power_monitor_bench.sv
// self-checking bench for the cpu clock and power monitor
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_and_power_monitor_bench
  import cpm_pkg::*;
;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  cpm_axi_req_t req = '0;
  cpm_axi_rsp_t rsp;
  logic         halve = 1'b0, lvl = 1'b1, raw = 1'b0, p_out = 1'b0, p_oe = 1'b0, h;
  logic         pod = 1'b0;
  logic [1:0]   osc = 2'h2;
  logic         co_o, co_oe, tick, lvl_hi, bo_rst_n, irq;
  logic [7:0]   n;
  logic [31:0]  rdat;
  logic [1:0]   rr;
  int           failures = 0, compares = 0, cyc = 0, per, p;
  // undriven pad is pulled low, so a stale value never looks like a clock
  tri0          pad;
  assign pad = co_oe ? co_o : 1'bz;
  always #25 aclk = ~aclk;
  cpm_top cpm_top_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .compat_halving_bit(halve), .brownout_level_select(lvl), .osc_select(osc),
    .brownout_below_raw(raw), .power_on_detect(pod), .port_pin_out(p_out),
    .port_pin_oe(p_oe), .clock_out_pin_o(co_o), .clock_out_pin_oe(co_oe),
    .cpu_clk_tick(tick), .brownout_level_high(lvl_hi), .brownout_reset_n(bo_rst_n),
    .irq(irq));
  cpm_clk_follower cpm_clk_follower_inst (.aclk(aclk), .pin(pad), .period(per));
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    while (aw || w)
    begin
      @(negedge aclk);
      aw = aw && !rsp.awready;
      w  = w && !rsp.wready;
      @(posedge aclk);
      req.awvalid <= aw;
      req.wvalid  <= w;
    end
    do @(negedge aclk); while (!rsp.bvalid);
    @(posedge aclk);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(negedge aclk); while (!rsp.arready);
    @(posedge aclk);
    req.arvalid <= 1'b0;
    do @(negedge aclk); while (!rsp.rvalid);
    rdat = rsp.rdata;
    rr   = rsp.rresp;
    @(posedge aclk);
    req.rready <= 1'b0;
  endtask : rd
  task automatic tick_per(output int t);
    do @(negedge aclk); while (!tick);
    t = 0;
    do
    begin
      @(negedge aclk);
      t++;
    end
    while (!tick);
  endtask : tick_per
  function automatic int tick_exp(logic [7:0] d, logic hv);
    return (d == 8'h00 ? 1 : 2 * (int'(d) + 1)) * (hv ? 2 : 1);
  endfunction : tick_exp
  always @(posedge aclk)
  begin
    cyc++;
    // every test together needs well under a third of this
    if (cyc == 30000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    rdat = $urandom(92289);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h014);
    chk("power after reset", rdat, 32'h1);
    rd(12'h000);
    chk("ctrl after reset", rdat, 32'h0);
    rd(12'h018);
    chk("unmapped resp", 32'(rr), 32'h2);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      n = (i == 0 || i == 4) ? 8'h00 : (i == 3) ? 8'hFF : 8'($urandom_range(1, 6));
      h = i[0] | (i == 4);
      halve <= h;
      wr(12'h004, 32'(n));
      tick_per(p);
      tick_per(p);
      chk("tick period", p, tick_exp(n, h));
    end
    $display("test divider done");
    halve <= 1'b0;
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge aclk);
      osc   <= 2'(i);
      p_out <= 1'($urandom);
      p_oe  <= 1'($urandom);
      lvl   <= 1'($urandom);
      repeat (80) @(posedge aclk);
      @(negedge aclk);
      chk("level high", 32'(lvl_hi), 32'(!lvl));
      chk("pad enable", 32'(co_oe), (i > 1) ? 32'h1 : 32'(p_oe));
      if (i > 1)
        chk("clock out period", per, 24);
      else
        chk("port drive", 32'(co_o), 32'(p_out));
    end
    $display("test clock out done");
    wr(12'h000, 32'h0);
    raw <= 1'b1;
    @(negedge aclk);
    chk("reset low", 32'(bo_rst_n), 32'h0);
    repeat (8) @(posedge aclk);
    chk("reset held", 32'(bo_rst_n), 32'h0);
    raw <= 1'b0;
    @(negedge aclk);
    chk("reset released", 32'(bo_rst_n), 32'h1);
    repeat (5) @(posedge aclk);
    rd(12'h014);
    chk("power flags", rdat, 32'h3);
    // a late power on indication must not count as a second power up
    pod <= 1'b1;
    wr(12'h014, 32'h3);
    rd(12'h014);
    chk("flags cleared", rdat, 32'h0);
    wr(12'h000, 32'h1E);
    raw <= 1'b1;
    @(negedge aclk);
    chk("disabled reset", 32'(bo_rst_n), 32'h1);
    repeat (8) @(posedge aclk);
    raw <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("disabled irq", 32'(irq), 32'h0);
    rd(12'h014);
    chk("disabled flag", rdat, 32'h0);
    $display("test brownout reset done");
    for (int m = 0; m < 2; m++)
    begin
      // first pass masks the global enable, second lets it through
      wr(12'h000, m ? 32'h1A : 32'h12);
      raw <= 1'b1;
      @(negedge aclk);
      chk("irq mode reset", 32'(bo_rst_n), 32'h1);
      repeat (8) @(posedge aclk);
      chk("irq", 32'(irq), 32'(m));
      rd(12'h008);
      chk("status", rdat, 32'h1);
      wr(12'h000, 32'h1A);
      chk("irq unmasked", 32'(irq), 32'h1);
      wr(12'h010, 32'h1);
      repeat (4) @(posedge aclk);
      chk("irq once", 32'(irq), 32'h0);
      raw <= 1'b0;
      repeat (5) @(posedge aclk);
    end
    rd(12'h014);
    chk("irq mode flag", rdat, 32'h2);
    $display("test brownout irq done");
    print_verdict();
  end
endmodule : cpu_clock_and_power_monitor_bench
`default_nettype wire
